//--- sop_consts.svh
/*
  Offsets, field positions, reset values and timing counts for the sync on/off pin block.
  Assumes a 100 MHz core clock and a byte-addressed register port with 32-bit words.
*/
`ifndef SOP_CONSTS_SVH
`define SOP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SOP_ADDR_CMD       8'h00
`define SOP_ADDR_STATUS    8'h04
`define SOP_ADDR_PIN0_CFG  8'h08
`define SOP_ADDR_PIN1_CFG  8'h0C
`define SOP_ADDR_PWM0_PER  8'h10
`define SOP_ADDR_PWM0_DUTY 8'h14
`define SOP_ADDR_PWM1_PER  8'h18
`define SOP_ADDR_PWM1_DUTY 8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SOP_CMD_ON_BIT    0
`define SOP_CMD_OFF_BIT   1
`define SOP_CFG_FUNC_LSB  0
`define SOP_CFG_INV_BIT   2
`define SOP_CFG_SRC_LSB   4
`define SOP_STAT_ON_BIT   0
`define SOP_STAT_LVL0_BIT 1
`define SOP_STAT_LVL1_BIT 2
`define SOP_STAT_TX0_BIT  3
`define SOP_STAT_TX1_BIT  4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SOP_PWM_PER_RST  16'h03E8
`define SOP_PWM_DUTY_RST 16'h01F4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SOP_CLK_PERIOD_NS 10
`define SOP_PULSE_MIN_NS  30000
`define SOP_PULSE_CYC ((`SOP_PULSE_MIN_NS + `SOP_CLK_PERIOD_NS - 1) / `SOP_CLK_PERIOD_NS)

`endif

//--- sop_pkg.sv
/*
  Types shared by the sync on/off pin block: pin functions, output sources, receiver states
  and the packed state of the pin channel and top modules.
  Assumes sop_consts.svh supplies the numeric constants.
*/
`default_nettype none

package sop_pkg;

  typedef logic [15:0] sop_cnt_t;

  typedef enum logic [1:0] {
    SOP_FN_SYNC   = 2'h0,
    SOP_FN_INPUT  = 2'h1,
    SOP_FN_OUTPUT = 2'h2,
    SOP_FN_RSVD   = 2'h3
  } sop_func_t;

  typedef enum logic [1:0] {
    SOP_SRC_LOW  = 2'h0,
    SOP_SRC_HIGH = 2'h1,
    SOP_SRC_PWM  = 2'h2,
    SOP_SRC_RSVD = 2'h3
  } sop_src_t;

  typedef enum logic [2:0] {
    SOP_RX_IDLE  = 3'h1,
    SOP_RX_COUNT = 3'h2,
    SOP_RX_WAIT  = 3'h4
  } sop_rx_t;

  typedef struct packed {
    sop_func_t func;
    logic      inv;
    sop_src_t  src;
    sop_cnt_t  per;
    sop_cnt_t  duty;
  } sop_pincfg_t;

  typedef struct packed {
    sop_rx_t  rxSt;
    sop_cnt_t rxCnt;
    sop_cnt_t txCnt;
    logic     txBusy;
    sop_cnt_t pwmCnt;
    logic     pinOut;
    logic     pinOe;
    logic     rxPulse;
    logic     rxLevel;
  } sop_chan_st_t;

  typedef struct packed {
    sop_pincfg_t [1:0] pin;
    logic              outOn;
    logic [1:0]        fire;
    logic [31:0]       rdata;
  } sop_top_st_t;

endpackage : sop_pkg

`default_nettype wire

//--- sop_chan_if.sv
/*
  Carrier between the register/control core and one pin channel.
  Assumes the control core drives configuration and start, the channel reports back.
*/
`default_nettype none

interface sop_chan_if;
  import sop_pkg::*;

  sop_pincfg_t cfg;
  logic        txStart;
  logic        rxPulse;
  logic        rxLevel;
  logic        txBusy;

  modport ctl  (output cfg, output txStart, input rxPulse, input rxLevel, input txBusy);
  modport chan (input cfg, input txStart, output rxPulse, output rxLevel, output txBusy);
endinterface : sop_chan_if

`default_nettype wire

//--- sop_pin_chan.sv
/*
  One configurable pin: sync pulse transmitter and qualified receiver, level input,
  and static or PWM output, all with selectable polarity.
  Assumes the pin input is already synchronous to clk and the line idles by an external pull.
*/
`include "sop_consts.svh"
`default_nettype none

module sop_pin_chan
  import sop_pkg::*;
#(
  parameter int PULSE_CYC = `SOP_PULSE_CYC
) (
  input  wire logic clk,    // core clock
  input  wire logic rst,    // async reset, high
  sop_chan_if.chan  ch,     // config and events
  input  wire logic pinIn,  // pin level seen
  output var  logic pinOut, // pin level driven
  output var  logic pinOe   // pin drive enable
);

  localparam sop_cnt_t PulseLast = sop_cnt_t'(PULSE_CYC - 1);

  sop_chan_st_t s_r;
  sop_chan_st_t s_nxt;
  logic         pulseAct;
  logic         srcBit;

  // active pulse level is low, or high when inverted
  assign pulseAct = ~(pinIn ^ ch.cfg.inv);

  always_comb begin
    s_nxt = s_r;
    srcBit = 1'b0;
    s_nxt.rxPulse = 1'b0;
    s_nxt.rxLevel = pinIn ^ ch.cfg.inv;

    // ----------------------------------------------------------------
    // pwm timebase
    // ----------------------------------------------------------------
    if (ch.cfg.per == '0 || s_r.pwmCnt >= ch.cfg.per - sop_cnt_t'(1)) begin
      s_nxt.pwmCnt = '0;
    end else begin
      s_nxt.pwmCnt = s_r.pwmCnt + sop_cnt_t'(1);
    end

    // ----------------------------------------------------------------
    // sync transmitter
    // ----------------------------------------------------------------
    if (s_r.txBusy) begin
      if (s_r.txCnt == PulseLast) begin
        s_nxt.txBusy = 1'b0;
      end else begin
        s_nxt.txCnt = s_r.txCnt + sop_cnt_t'(1);
      end
    end else if (ch.txStart && ch.cfg.func == SOP_FN_SYNC) begin
      s_nxt.txBusy = 1'b1;
      s_nxt.txCnt = '0;
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    case (ch.cfg.src)
      SOP_SRC_HIGH: srcBit = 1'b1;
      SOP_SRC_PWM:  srcBit = s_r.pwmCnt < ch.cfg.duty;
      default:      srcBit = 1'b0;
    endcase
    case (ch.cfg.func)
      SOP_FN_SYNC: begin
        s_nxt.pinOe = s_nxt.txBusy;
        s_nxt.pinOut = s_nxt.txBusy & ch.cfg.inv;
      end
      SOP_FN_OUTPUT: begin
        s_nxt.pinOe = 1'b1;
        s_nxt.pinOut = ~srcBit ^ ch.cfg.inv;
      end
      default: begin
        s_nxt.pinOe = 1'b0;
        s_nxt.pinOut = 1'b0;
      end
    endcase

    // ----------------------------------------------------------------
    // sync receiver
    // ----------------------------------------------------------------
    // own pulse would read back as a received one, so the receiver sits out while sending
    if (ch.cfg.func != SOP_FN_SYNC || s_r.txBusy || s_nxt.txBusy) begin
      s_nxt.rxSt = SOP_RX_IDLE;
      s_nxt.rxCnt = '0;
    end else begin
      case (s_r.rxSt)
        SOP_RX_IDLE: begin
          if (pulseAct) begin
            s_nxt.rxSt = SOP_RX_COUNT;
            s_nxt.rxCnt = sop_cnt_t'(1);
          end
        end
        SOP_RX_COUNT: begin
          if (!pulseAct) begin
            s_nxt.rxSt = SOP_RX_IDLE;
          end else if (s_r.rxCnt >= PulseLast) begin
            s_nxt.rxSt = SOP_RX_WAIT;
            s_nxt.rxPulse = 1'b1;
          end else begin
            s_nxt.rxCnt = s_r.rxCnt + sop_cnt_t'(1);
          end
        end
        SOP_RX_WAIT: begin
          // one event per pulse, however long it is held
          if (!pulseAct) begin
            s_nxt.rxSt = SOP_RX_IDLE;
          end
        end
        default: s_nxt.rxSt = SOP_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{rxSt: SOP_RX_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pinOut = s_r.pinOut;
  assign pinOe = s_r.pinOe;
  assign ch.rxPulse = s_r.rxPulse;
  assign ch.rxLevel = s_r.rxLevel;
  assign ch.txBusy = s_r.txBusy;

endmodule : sop_pin_chan

`default_nettype wire

//--- sop_io_pins.sv
/*
  Two configurable I/O pins of an instrument control port: the first links output switch-on
  between instruments, the second links switch-off; either may instead be a level input or a
  static or PWM output. Holds the output on/off state and the register port.
  Assumes a single-cycle register master with no wait states and synchronous pin inputs.
*/
// Local design decisions: the register offsets and the plain strobed port.
`include "sop_consts.svh"
`default_nettype none

module sop_io_pins
  import sop_pkg::*;
#(
  parameter int PULSE_CYC = `SOP_PULSE_CYC
) (
  input  wire logic        clk,       // core clock
  input  wire logic        rst,       // async reset, high
  input  wire logic [7:0]  regAddr,   // register byte address
  input  wire logic [31:0] regWdata,  // write data
  input  wire logic        regWr,     // write strobe
  input  wire logic        regRd,     // read strobe
  output var  logic [31:0] regRdata,  // read data, cycle after strobe
  output var  logic        outputOn,  // instrument output state
  input  wire logic        pin0In,    // switch-on pin level
  output var  logic        pin0Out,   // switch-on pin drive level
  output var  logic        pin0Oe,    // switch-on pin drive enable
  input  wire logic        pin1In,    // switch-off pin level
  output var  logic        pin1Out,   // switch-off pin drive level
  output var  logic        pin1Oe     // switch-off pin drive enable
);

  // ----------------------------------------------------------------
  // config field helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cfgRead(input sop_pincfg_t c);
    logic [31:0] w;
    w = '0;
    w[`SOP_CFG_FUNC_LSB +: 2] = c.func;
    w[`SOP_CFG_INV_BIT] = c.inv;
    w[`SOP_CFG_SRC_LSB +: 2] = c.src;
    return w;
  endfunction : cfgRead

  function automatic sop_pincfg_t cfgWrite(input sop_pincfg_t c, input logic [31:0] w);
    sop_pincfg_t n;
    n = c;
    n.func = sop_func_t'(w[`SOP_CFG_FUNC_LSB +: 2]);
    n.inv = w[`SOP_CFG_INV_BIT];
    n.src = sop_src_t'(w[`SOP_CFG_SRC_LSB +: 2]);
    return n;
  endfunction : cfgWrite

  // ----------------------------------------------------------------
  // state and channel carriers
  // ----------------------------------------------------------------
  sop_top_st_t s_r;
  sop_top_st_t s_nxt;
  sop_chan_if  onCh ();
  sop_chan_if  offCh ();
  logic        cmdWr;
  logic        cmdOn;
  logic        cmdOff;

  // both command bits at once is ambiguous, so it does nothing
  assign cmdWr = regWr && (regAddr == `SOP_ADDR_CMD);
  assign cmdOn = cmdWr && regWdata[`SOP_CMD_ON_BIT] && !regWdata[`SOP_CMD_OFF_BIT];
  assign cmdOff = cmdWr && regWdata[`SOP_CMD_OFF_BIT] && !regWdata[`SOP_CMD_ON_BIT];

  always_comb begin
    s_nxt = s_r;
    s_nxt.fire = 2'h0;
    s_nxt.rdata = 32'h0000_0000;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (regWr) begin
      if (regAddr == `SOP_ADDR_PIN0_CFG) begin
        s_nxt.pin[0] = cfgWrite(s_r.pin[0], regWdata);
      end else if (regAddr == `SOP_ADDR_PIN1_CFG) begin
        s_nxt.pin[1] = cfgWrite(s_r.pin[1], regWdata);
      end else if (regAddr == `SOP_ADDR_PWM0_PER) begin
        s_nxt.pin[0].per = regWdata[15:0];
      end else if (regAddr == `SOP_ADDR_PWM0_DUTY) begin
        s_nxt.pin[0].duty = regWdata[15:0];
      end else if (regAddr == `SOP_ADDR_PWM1_PER) begin
        s_nxt.pin[1].per = regWdata[15:0];
      end else if (regAddr == `SOP_ADDR_PWM1_DUTY) begin
        s_nxt.pin[1].duty = regWdata[15:0];
      end
    end

    // ----------------------------------------------------------------
    // output on/off state
    // ----------------------------------------------------------------
    // local command beats a pulse arriving in the same cycle; the pulse is then moot
    if (cmdOn) begin
      if (!s_r.outOn) begin
        s_nxt.outOn = 1'b1;
        s_nxt.fire[0] = 1'b1;
      end
    end else if (cmdOff) begin
      if (s_r.outOn) begin
        s_nxt.outOn = 1'b0;
        s_nxt.fire[1] = 1'b1;
      end
    end else if (onCh.rxPulse && !s_r.outOn) begin
      s_nxt.outOn = 1'b1;
    end else if (offCh.rxPulse && s_r.outOn) begin
      s_nxt.outOn = 1'b0;
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    if (regRd) begin
      if (regAddr == `SOP_ADDR_STATUS) begin
        s_nxt.rdata[`SOP_STAT_ON_BIT] = s_r.outOn;
        s_nxt.rdata[`SOP_STAT_LVL0_BIT] = onCh.rxLevel;
        s_nxt.rdata[`SOP_STAT_LVL1_BIT] = offCh.rxLevel;
        s_nxt.rdata[`SOP_STAT_TX0_BIT] = onCh.txBusy;
        s_nxt.rdata[`SOP_STAT_TX1_BIT] = offCh.txBusy;
      end else if (regAddr == `SOP_ADDR_PIN0_CFG) begin
        s_nxt.rdata = cfgRead(s_r.pin[0]);
      end else if (regAddr == `SOP_ADDR_PIN1_CFG) begin
        s_nxt.rdata = cfgRead(s_r.pin[1]);
      end else if (regAddr == `SOP_ADDR_PWM0_PER) begin
        s_nxt.rdata[15:0] = s_r.pin[0].per;
      end else if (regAddr == `SOP_ADDR_PWM0_DUTY) begin
        s_nxt.rdata[15:0] = s_r.pin[0].duty;
      end else if (regAddr == `SOP_ADDR_PWM1_PER) begin
        s_nxt.rdata[15:0] = s_r.pin[1].per;
      end else if (regAddr == `SOP_ADDR_PWM1_DUTY) begin
        s_nxt.rdata[15:0] = s_r.pin[1].duty;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // both pins come up in their sync function, not inverted
      s_r.pin[0] <= '{func: SOP_FN_SYNC, inv: 1'b0, src: SOP_SRC_LOW,
                      per: `SOP_PWM_PER_RST, duty: `SOP_PWM_DUTY_RST};
      s_r.pin[1] <= '{func: SOP_FN_SYNC, inv: 1'b0, src: SOP_SRC_LOW,
                      per: `SOP_PWM_PER_RST, duty: `SOP_PWM_DUTY_RST};
      s_r.outOn <= 1'b0;
      s_r.fire <= 2'h0;
      s_r.rdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin channels
  // ----------------------------------------------------------------
  assign onCh.cfg = s_r.pin[0];
  assign onCh.txStart = s_r.fire[0];
  assign offCh.cfg = s_r.pin[1];
  assign offCh.txStart = s_r.fire[1];

  sop_pin_chan #(
    .PULSE_CYC (PULSE_CYC)
  ) u_onPin (
    .clk    (clk),
    .rst    (rst),
    .ch     (onCh),
    .pinIn  (pin0In),
    .pinOut (pin0Out),
    .pinOe  (pin0Oe)
  );

  sop_pin_chan #(
    .PULSE_CYC (PULSE_CYC)
  ) u_offPin (
    .clk    (clk),
    .rst    (rst),
    .ch     (offCh),
    .pinIn  (pin1In),
    .pinOut (pin1Out),
    .pinOe  (pin1Oe)
  );

  assign regRdata = s_r.rdata;
  assign outputOn = s_r.outOn;

endmodule : sop_io_pins

`default_nettype wire

//--- sop_io_pins_asserts.sv
/*
  Concurrent checks on the ports of the sync on/off pin block.
  Assumes pin inputs carry the resolved line level and config is written over the register port.
*/
`include "sop_consts.svh"
`default_nettype none

module sop_io_pins_asserts
  import sop_pkg::*;
#(
  parameter int PULSE_CYC = `SOP_PULSE_CYC
) (
  input wire logic        clk,      // core clock
  input wire logic        rst,      // async reset, high
  input wire logic [7:0]  regAddr,  // register address
  input wire logic [31:0] regWdata, // write data
  input wire logic        regWr,    // write strobe
  input wire logic        regRd,    // read strobe
  input wire logic [31:0] regRdata, // read data
  input wire logic        outputOn, // output state
  input wire logic        pin0In,   // switch-on line
  input wire logic        pin0Out,  // switch-on drive
  input wire logic        pin0Oe,   // switch-on enable
  input wire logic        pin1In,   // switch-off line
  input wire logic        pin1Out,  // switch-off drive
  input wire logic        pin1Oe    // switch-off enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // shadow of config, active-run and drive-run counters
  // ------------------------------------------------------------
  logic [5:0]  cfg0_r, cfg1_r;
  logic [15:0] act0_r, act1_r, oeN0_r, oeN1_r;
  wire logic   onCmd  = regWr && regAddr == `SOP_ADDR_CMD && regWdata[1:0] == 2'h1;
  wire logic   offCmd = regWr && regAddr == `SOP_ADDR_CMD && regWdata[1:0] == 2'h2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg0_r <= 6'h00;
      cfg1_r <= 6'h00;
      act0_r <= 16'h0;
      act1_r <= 16'h0;
      oeN0_r <= 16'h0;
      oeN1_r <= 16'h0;
    end else begin
      if (regWr && regAddr == `SOP_ADDR_PIN0_CFG) cfg0_r <= regWdata[5:0];
      if (regWr && regAddr == `SOP_ADDR_PIN1_CFG) cfg1_r <= regWdata[5:0];
      // own drive masks the receiver, so only count while released
      act0_r <= (!pin0Oe && !(pin0In ^ cfg0_r[2])) ? act0_r + 16'h1 : 16'h0;
      act1_r <= (!pin1Oe && !(pin1In ^ cfg1_r[2])) ? act1_r + 16'h1 : 16'h0;
      oeN0_r <= pin0Oe ? oeN0_r + 16'h1 : 16'h0;
      oeN1_r <= pin1Oe ? oeN1_r + 16'h1 : 16'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_tx_on_start: assert property ($rose(outputOn) && $past(onCmd) && !pin0Oe
    && cfg0_r[1:0] == SOP_FN_SYNC |=> pin0Oe && pin0Out == cfg0_r[2])
    else $error("no switch-on pulse after local on");
  chk_tx_off_start: assert property ($fell(outputOn) && $past(offCmd) && !pin1Oe
    && cfg1_r[1:0] == SOP_FN_SYNC |=> pin1Oe && pin1Out == cfg1_r[2])
    else $error("no switch-off pulse after local off");
  chk_tx_len_on: assert property ($fell(pin0Oe) && cfg0_r[1:0] == SOP_FN_SYNC
    && $past(cfg0_r, 2) == cfg0_r |-> oeN0_r == PULSE_CYC)
    else $error("switch-on pulse length wrong");
  chk_tx_len_off: assert property ($fell(pin1Oe) && cfg1_r[1:0] == SOP_FN_SYNC
    && $past(cfg1_r, 2) == cfg1_r |-> oeN1_r == PULSE_CYC)
    else $error("switch-off pulse length wrong");
  chk_rx_turn_on: assert property (act0_r == PULSE_CYC && !outputOn && !regWr
    && cfg0_r[1:0] == SOP_FN_SYNC |-> ##[0:2] outputOn)
    else $error("received switch-on pulse ignored");
  chk_rx_turn_off: assert property (act1_r == PULSE_CYC && outputOn && !regWr
    && cfg1_r[1:0] == SOP_FN_SYNC |-> ##[0:2] !outputOn)
    else $error("received switch-off pulse ignored");
  chk_on_has_cause: assert property ($rose(outputOn) |->
    $past(onCmd) || $past(act0_r) >= PULSE_CYC - 1)
    else $error("output turned on without cause");
  chk_out_level: assert property (cfg0_r[1:0] == SOP_FN_OUTPUT
    && cfg0_r[5:4] != SOP_SRC_PWM && $past(cfg0_r) == cfg0_r |-> pin0Oe
    && pin0Out == ((cfg0_r[5:4] != SOP_SRC_HIGH) ^ cfg0_r[2]))
    else $error("static output level wrong");
  chk_in_released: assert property (cfg0_r[1:0] == SOP_FN_INPUT
    && $past(cfg0_r) == cfg0_r |-> !pin0Oe)
    else $error("input pin is driven");
  chk_rd_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read cycle");

  cov_tx_on: cover property ($rose(pin0Oe) && cfg0_r[1:0] == SOP_FN_SYNC);
  cov_rx_on: cover property (act0_r == PULSE_CYC && !outputOn);
  cov_rx_off: cover property (act1_r == PULSE_CYC && outputOn);
endmodule : sop_io_pins_asserts

bind sop_io_pins sop_io_pins_asserts #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .outputOn(outputOn), .pin0In(pin0In), .pin0Out(pin0Out), .pin0Oe(pin0Oe), .pin1In(pin1In),
  .pin1Out(pin1Out), .pin1Oe(pin1Oe));

`default_nettype wire

//--- sop_peer.sv
/*
  Matching sync pin of another instrument: pulls the shared line low for a set time.
  Assumes the line has a pull-up, so releasing it returns the line high.
*/
`default_nettype none

module sop_peer (
  input  wire logic       clk,    // core clock
  input  wire logic       fire,   // start a pulse
  input  wire logic [7:0] width,  // pulse length in cycles
  output var  logic       drvLow  // pulling the line low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;

  initial begin
    cnt = 8'h00;
    drvLow = 1'h0;
  end

  // width is the caller's to choose, so a short one probes the receiver filter
  always @(posedge clk) begin
    if (fire) begin
      cnt <= width;
      drvLow <= 1'h1;
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else begin
      cnt <= 8'h00;
      drvLow <= 1'h0;
    end
  end
endmodule : sop_peer

`default_nettype wire

//--- sop_io_pins_tb.sv
/*
  Self-checking bench for the sync on/off pins with a peer on each line.
  Assumes a shortened pulse length and pulled-up lines.
*/
`include "sop_consts.svh"
`default_nettype none

module sop_io_pins_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 8;
  typedef struct {logic [5:0] c; logic oe; logic out;} sop_row_t;
  typedef struct {logic [1:0] k; logic [7:0] v; logic on;
                  logic [7:0] e0; logic [7:0] e1;} sop_step_t;
  typedef struct {logic [7:0] a; logic [31:0] v;} sop_rd_t;
  logic        clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0, fire0 = 1'h0, fire1 = 1'h0;
  logic        tbLow0 = 1'h0, tbLow1 = 1'h0, o0, o1, outputOn, pin0Out, pin0Oe, pin1Out, pin1Oe;
  logic        low0, low1;
  logic [7:0]  regAddr = 8'h00, width = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, d;
  int          mismatches = 0, compares = 0, cycles = 0, n0, n1;
  wire logic   pin0 = !((pin0Oe && !pin0Out) || low0 || tbLow0);
  wire logic   pin1 = !((pin1Oe && !pin1Out) || low1 || tbLow1);
  sop_row_t  rows[7] = '{'{6'h02, 1'h1, 1'h1}, '{6'h12, 1'h1, 1'h0}, '{6'h06, 1'h1, 1'h0},
                         '{6'h16, 1'h1, 1'h1}, '{6'h32, 1'h1, 1'h1}, '{6'h01, 1'h0, 1'h0},
                         '{6'h03, 1'h0, 1'h0}};
  sop_step_t seq[9] = '{'{2'h0, 8'h3, 1'h0, 8'h0, 8'h0}, '{2'h0, 8'h1, 1'h1, 8'(P), 8'h0},
    '{2'h0, 8'h1, 1'h1, 8'h0, 8'h0}, '{2'h1, 8'(P), 1'h1, 8'h0, 8'h0},
    '{2'h2, 8'(P - 1), 1'h1, 8'h0, 8'h0}, '{2'h2, 8'(P), 1'h0, 8'h0, 8'h0},
    '{2'h2, 8'(P), 1'h0, 8'h0, 8'h0}, '{2'h1, 8'(P), 1'h1, 8'h0, 8'h0},
    '{2'h0, 8'h2, 1'h0, 8'h0, 8'(P)}};
  sop_rd_t   rdTab[8] = '{'{`SOP_ADDR_CMD, 32'h0}, '{`SOP_ADDR_PIN0_CFG, 32'h22},
    '{`SOP_ADDR_PIN1_CFG, 32'h5}, '{`SOP_ADDR_PWM0_PER, 32'h3E8}, '{`SOP_ADDR_PWM0_DUTY, 32'hFA},
    '{`SOP_ADDR_PWM1_PER, 32'h3E8}, '{`SOP_ADDR_PWM1_DUTY, 32'h1F4}, '{8'h20, 32'h0}};

  always #5 clk = ~clk;

  sop_io_pins #(.PULSE_CYC(P)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .outputOn(outputOn), .pin0In(pin0), .pin0Out(pin0Out), .pin0Oe(pin0Oe),
    .pin1In(pin1), .pin1Out(pin1Out), .pin1Oe(pin1Oe));
  sop_peer peer0 (.clk(clk), .fire(fire0), .width(width), .drvLow(low0));
  sop_peer peer1 (.clk(clk), .fire(fire1), .width(width), .drvLow(low1));

  // ------------------------------------------------------------
  // bus, peer and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1 v = regRdata;
    @(posedge clk);
  endtask : rd

  task automatic peer(input logic p, input logic [7:0] w);
    width <= w;
    if (p) fire1 <= 1'h1;
    else fire0 <= 1'h1;
    @(posedge clk);
    fire0 <= 1'h0;
    fire1 <= 1'h0;
  endtask : peer

  // counts drive cycles on both pins; samples settle 1 ns after each edge
  task automatic win();
    n0 = 0;
    n1 = 0;
    repeat (30) begin
      #1;
      if (pin0Oe === 1'h1) begin n0++; o0 = pin0Out; end
      if (pin1Oe === 1'h1) begin n1++; o1 = pin1Out; end
      @(posedge clk);
    end
  endtask : win

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    #1 chk("reset", {29'h0, outputOn, pin0Oe, pin1Oe}, 32'h0);
    chk("resetRd", regRdata, 32'h0);
    @(posedge clk);
    rd(`SOP_ADDR_PIN1_CFG, d);
    chk("resetCfg", d, 32'h0);
    foreach (seq[i]) begin
      if (seq[i].k == 2'h0) wr(`SOP_ADDR_CMD, 32'(seq[i].v));
      else peer(seq[i].k == 2'h2, seq[i].v);
      win();
      chk("syncOn", outputOn, seq[i].on);
      chk("syncTx", {8'(n0), 8'(n1)}, {seq[i].e0, seq[i].e1});
    end
    // the held-low line keeps the inverted receiver from seeing an idle high as a pulse
    tbLow0 <= 1'h1;
    wr(`SOP_ADDR_PIN0_CFG, 32'h4);
    wr(`SOP_ADDR_CMD, 32'h1);
    win();
    chk("invTx", {outputOn, o0, 8'(n0)}, {2'h3, 8'(P)});
    wr(`SOP_ADDR_PIN0_CFG, 32'h0);
    tbLow0 <= 1'h0;
    for (int p = 0; p < 2; p++) begin
      foreach (rows[i]) begin
        wr(p ? `SOP_ADDR_PIN1_CFG : `SOP_ADDR_PIN0_CFG, {26'h0, rows[i].c});
        @(posedge clk);
        #1 d = p ? {30'h0, pin1Oe, pin1Oe & pin1Out} : {30'h0, pin0Oe, pin0Oe & pin0Out};
        chk("modeOe", d[1], rows[i].oe);
        chk("modeLvl", d[0], rows[i].out);
        @(posedge clk);
      end
    end
    tbLow1 <= 1'h1;
    wr(`SOP_ADDR_PIN1_CFG, 32'h1);
    rd(`SOP_ADDR_STATUS, d);
    chk("lvlLow", d & 32'h1D, 32'h1);
    tbLow1 <= 1'h0;
    repeat (2) @(posedge clk);
    rd(`SOP_ADDR_STATUS, d);
    chk("lvlHigh", d & 32'h1D, 32'h5);
    wr(`SOP_ADDR_PIN1_CFG, 32'h5);
    rd(`SOP_ADDR_STATUS, d);
    chk("lvlInv", d & 32'h1D, 32'h1);
    // inverted sync receiver: an idle-low line, then a high pulse of the full width
    tbLow1 <= 1'h1;
    wr(`SOP_ADDR_PIN1_CFG, 32'h4);
    tbLow1 <= 1'h0;
    repeat (P) @(posedge clk);
    tbLow1 <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk("invRx", outputOn, 1'h0);
    @(posedge clk);
    wr(`SOP_ADDR_PIN1_CFG, 32'h5);
    wr(`SOP_ADDR_PWM0_DUTY, 32'hFA);
    wr(`SOP_ADDR_PIN0_CFG, 32'h22);
    @(posedge clk);
    n0 = 0;
    repeat (1000) begin
      #1 n0 += (pin0Out === 1'h0);
      @(posedge clk);
    end
    chk("pwmLow", n0, 32'hFA);
    foreach (rdTab[i]) begin
      rd(rdTab[i].a, d);
      chk("reg", d, rdTab[i].v);
    end
    close_out();
  end
endmodule : sop_io_pins_tb

`default_nettype wire
